// ### hw/uirb_top.sv
// uirb_top.sv - serial receive/transmit core with infrared coding and fractional baud generation
`timescale 1ns/1ns
module uirb_top
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial lines
	input wire logic serial_rx_line,
	output logic serial_tx_line,
	// buffer flags
	output logic rx_irq_flag,
	output logic tx_irq_flag
);

	function automatic logic maj3(input logic a, input logic b, input logic c);
		maj3 = (a & b) | (a & c) | (b & c);
	endfunction

	logic rst_meta;
	logic rst_sync_n;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// configuration
	logic [12:0] ctrl;
	logic [15:0] baud_prescaler;
	logic [2:0] second_stage_modulation;
	logic [3:0] first_stage_modulation;
	logic [5:0] ir_tx_pulse_len;
	logic [5:0] ir_rx_filter_length;
	logic [7:0] rx_buffer;
	logic [7:0] tx_buffer;
	logic framing_error_flag;
	logic parity_error_flag;
	logic overrun_flag;
	logic break_flag;
	logic rx_error_summary;
	logic idle_line_flag;
	logic ov_since_stat;
	uirb_pkg::uirb_rx_state_t rx_state;
	uirb_pkg::uirb_tx_state_t tx_state;

	wire soft_reset_bit = ctrl[uirb_pkg::CTRL_SWRST];
	wire oversample_select = ctrl[uirb_pkg::CTRL_OS16];
	wire infrared_coding_enable = ctrl[uirb_pkg::CTRL_IREN];
	wire ir_tx_pulse_clock_select = ctrl[uirb_pkg::CTRL_IRTXCLK];
	wire ir_rx_polarity = ctrl[uirb_pkg::CTRL_IRRXPL];
	wire ir_rx_filter_enable = ctrl[uirb_pkg::CTRL_IRRXFE];
	wire rx_error_irq_enable = ctrl[uirb_pkg::CTRL_RXEIE];
	wire break_irq_enable = ctrl[uirb_pkg::CTRL_BRKIE];
	wire [1:0] serial_mode_field = ctrl[uirb_pkg::CTRL_MODE +: 2];
	wire parity_enable = ctrl[uirb_pkg::CTRL_PAREN];
	wire parity_even = ctrl[uirb_pkg::CTRL_PAREVEN];
	wire two_stop = ctrl[uirb_pkg::CTRL_TWOSTOP];

	// apb decode; registers answer in the access cycle right after setup
	wire hit_ctrl = paddr == uirb_pkg::REG_CTRL;
	wire hit_baud = paddr == uirb_pkg::REG_BAUD;
	wire hit_irctl = paddr == uirb_pkg::REG_IRCTL;
	wire hit_status = paddr == uirb_pkg::REG_STATUS;
	wire hit_rxbuf = paddr == uirb_pkg::REG_RXBUF;
	wire hit_txbuf = paddr == uirb_pkg::REG_TXBUF;
	wire hit_flags = paddr == uirb_pkg::REG_FLAGS;
	wire mapped = hit_ctrl | hit_baud | hit_irctl | hit_status | hit_rxbuf | hit_txbuf | hit_flags;
	wire apb_setup = psel & ~penable;
	wire apb_done = psel & penable & pready;
	wire wr_any = apb_done & pwrite;
	wire rd_any = apb_done & ~pwrite;
	wire rd_status = rd_any & hit_status;
	wire rd_rxbuf = rd_any & hit_rxbuf;
	wire wr_status = wr_any & hit_status;
	wire wr_txbuf = wr_any & hit_txbuf;

	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0;
		if (hit_ctrl)
			rd_mux[uirb_pkg::CTRL_W-1:0] = ctrl;
		if (hit_baud)
			rd_mux = {8'h0, first_stage_modulation, 1'b0, second_stage_modulation, baud_prescaler};
		if (hit_irctl)
			rd_mux = {18'h0, ir_rx_filter_length, 2'b0, ir_tx_pulse_len};
		if (hit_status)
			rd_mux[7:0] = {tx_state != uirb_pkg::TX_IDLE, rx_state != uirb_pkg::RX_IDLE, idle_line_flag,
				rx_error_summary, break_flag, overrun_flag, parity_error_flag, framing_error_flag};
		if (hit_rxbuf)
			rd_mux[7:0] = rx_buffer;
		if (hit_txbuf)
			rd_mux[7:0] = tx_buffer;
		if (hit_flags)
			rd_mux[1:0] = {tx_irq_flag, rx_irq_flag};
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= apb_setup;
			pslverr <= apb_setup & ~mapped;
			prdata <= (apb_setup & ~pwrite) ? rd_mux : 32'h0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			ctrl <= uirb_pkg::CTRL_RESET;
			baud_prescaler <= 16'h0000;
			second_stage_modulation <= 3'h0;
			first_stage_modulation <= 4'h0;
			ir_tx_pulse_len <= 6'h00;
			ir_rx_filter_length <= 6'h00;
		end
		else
		begin
			if (wr_any & hit_ctrl)
				ctrl <= pwdata[uirb_pkg::CTRL_W-1:0];
			if (wr_any & hit_baud)
			begin
				baud_prescaler <= pwdata[uirb_pkg::BAUD_PRESC +: 16];
				second_stage_modulation <= pwdata[uirb_pkg::BAUD_MOD2 +: 3];
				first_stage_modulation <= pwdata[uirb_pkg::BAUD_MOD1 +: 4];
			end
			if (wr_any & hit_irctl)
			begin
				ir_tx_pulse_len <= pwdata[uirb_pkg::IR_TXPL +: 6];
				ir_rx_filter_length <= pwdata[uirb_pkg::IR_RXFL +: 6];
			end
		end
	end

	// baud generators: channel 0 receive, channel 1 transmit; both held cleared (counter, tick and bit index at zero) while run is low
	wire [7:0] mod2_pat = uirb_pkg::M2_TAB[second_stage_modulation];
	wire [15:0] mod1_pat = uirb_pkg::M1_TAB[first_stage_modulation];
	logic [1:0] gen_run;
	logic [1:0] gen_restart;
	logic [1:0] gen_bend;
	logic [1:0] gen_s1;
	logic [1:0] gen_s2;
	logic [1:0] gen_s3;
	for (genvar g = 0; g < 2; g++)
	begin : g_baud
		logic [15:0] cnt;
		logic [4:0] tick;
		logic [2:0] bidx;
		wire m2b = mod2_pat[bidx];
		wire m1b = tick[4] ? 1'b0 : mod1_pat[tick[3:0]];
		wire [16:0] tper = {1'b0, baud_prescaler} + {16'h0, oversample_select ? m1b : m2b};
		wire tend = ({1'b0, cnt} + 17'h1) >= tper;
		// the extra second-stage 16x period carries no first-stage lengthening
		wire last_tick = !oversample_select || (tick == uirb_pkg::OS_LAST_TICK + {4'h0, m2b});
		wire [16:0] half = {1'b0, tper[16:1]};
		assign gen_bend[g] = gen_run[g] & tend & last_tick;
		assign gen_s1[g] = gen_run[g] & (oversample_select ? (tend && tick == uirb_pkg::OS_SAMP_TICK)
			: ({1'b0, cnt} + 17'h1 == half));
		assign gen_s2[g] = gen_run[g] & (oversample_select ? (tend && tick == uirb_pkg::OS_SAMP_TICK + 5'h1)
			: ({1'b0, cnt} == half));
		assign gen_s3[g] = gen_run[g] & (oversample_select ? (tend && tick == uirb_pkg::OS_SAMP_TICK + 5'h2)
			: ({1'b0, cnt} == half + 17'h1));
		always_ff @(posedge sys_clk or negedge rst_sync_n)
		begin
			if (!rst_sync_n)
			begin
				cnt <= 16'h0000;
				tick <= 5'h00;
				bidx <= 3'h0;
			end
			else if (!gen_run[g] || gen_restart[g])
			begin
				cnt <= 16'h0000;
				tick <= 5'h00;
				bidx <= 3'h0;
			end
			else if (tend)
			begin
				cnt <= 16'h0000;
				if (last_tick)
				begin
					tick <= 5'h00;
					bidx <= bidx + 3'h1;
				end
				else
					tick <= tick + 5'h01;
			end
			else
				cnt <= cnt + 16'h0001;
		end
	end

	// receive front end: synchroniser, infrared decoder, deglitch
	logic rx_meta;
	logic rx_s;
	logic [6:0] ir_pw;
	logic ir_taken;
	logic [20:0] ir_str;
	logic [4:0] dg_cnt;
	logic line_f;
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			rx_meta <= 1'b1;
			rx_s <= 1'b1;
		end
		else
		begin
			rx_meta <= serial_rx_line;
			rx_s <= rx_meta;
		end
	end

	wire ir_active = ir_rx_polarity ? !rx_s : rx_s;
	wire ir_accept = ir_active && !ir_taken && (!ir_rx_filter_enable || ir_pw > {1'b0, ir_rx_filter_length});
	// a short infrared pulse is stretched over the sample window of its bit
	wire [20:0] ir_stretch = oversample_select ? {5'h00, baud_prescaler} * uirb_pkg::IR_STRETCH_OS
		: ({5'h00, baud_prescaler} * uirb_pkg::IR_STRETCH_LF) >> 2;
	wire rx_raw = infrared_coding_enable ? (ir_str == 21'h0) : rx_s;
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			ir_pw <= 7'h00;
			ir_taken <= 1'b0;
			ir_str <= 21'h0;
		end
		else
		begin
			if (!ir_active)
			begin
				ir_pw <= 7'h00;
				ir_taken <= 1'b0;
			end
			else
			begin
				if (ir_pw != uirb_pkg::IR_PW_MAX)
					ir_pw <= ir_pw + 7'h01;
				if (ir_accept)
					ir_taken <= 1'b1;
			end
			if (!infrared_coding_enable)
				ir_str <= 21'h0;
			else if (ir_accept)
				ir_str <= ir_stretch;
			else if (ir_str != 21'h0)
				ir_str <= ir_str - 21'h1;
		end
	end

	// a level change is taken only after it held for the whole deglitch time
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			dg_cnt <= 5'h00;
			line_f <= 1'b1;
		end
		else if (rx_raw == line_f)
			dg_cnt <= 5'h00;
		else if (dg_cnt == uirb_pkg::DEGLITCH_LAST)
		begin
			line_f <= rx_raw;
			dg_cnt <= 5'h00;
		end
		else
			dg_cnt <= dg_cnt + 5'h01;
	end

	// receive state machine
	logic [1:0] vs;
	logic [3:0] rx_bits;
	logic [7:0] rx_sh;
	logic rx_par;
	logic rx_stop_cnt;
	logic rx_stop_low;
	logic rx_done;
	logic rx_fe_c;
	logic rx_pe_c;
	logic rx_brk_c;
	logic idle_set;
	logic [3:0] ones_cnt;
	wire vote = maj3(vs[1], vs[0], line_f);
	wire bitv = gen_s3[0];
	assign gen_run[0] = !soft_reset_bit && rx_state != uirb_pkg::RX_IDLE;
	assign gen_restart[0] = rx_state == uirb_pkg::RX_WAITIDLE && !line_f;

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			vs <= 2'b11;
		else if (gen_s1[0] | gen_s2[0])
			vs <= {vs[0], line_f};
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			rx_state <= uirb_pkg::RX_IDLE;
			rx_bits <= 4'h0;
			rx_sh <= 8'h00;
			rx_par <= 1'b0;
			rx_stop_cnt <= 1'b0;
			rx_stop_low <= 1'b0;
			rx_done <= 1'b0;
			rx_fe_c <= 1'b0;
			rx_pe_c <= 1'b0;
			rx_brk_c <= 1'b0;
			idle_set <= 1'b0;
			ones_cnt <= 4'h0;
		end
		else
		begin
			rx_done <= 1'b0;
			idle_set <= 1'b0;
			if (soft_reset_bit)
				rx_state <= uirb_pkg::RX_IDLE;
			else
			begin
				case (rx_state)
					uirb_pkg::RX_IDLE, uirb_pkg::RX_WAITIDLE:
					begin
						if (!line_f)
						begin
							rx_state <= uirb_pkg::RX_START;
							rx_stop_cnt <= 1'b0;
							rx_stop_low <= 1'b0;
						end
						else if (rx_state == uirb_pkg::RX_WAITIDLE && bitv && vote)
						begin
							if (ones_cnt == uirb_pkg::IDLE_LAST)
							begin
								idle_set <= 1'b1;
								rx_state <= uirb_pkg::RX_IDLE;
							end
							else
								ones_cnt <= ones_cnt + 4'h1;
						end
					end
					uirb_pkg::RX_START:
						if (bitv)
						begin
							rx_state <= vote ? uirb_pkg::RX_IDLE : uirb_pkg::RX_DATA;
							rx_bits <= 4'h0;
						end
					uirb_pkg::RX_DATA:
						if (bitv)
						begin
							rx_sh <= {vote, rx_sh[7:1]};
							rx_bits <= rx_bits + 4'h1;
							if (rx_bits == uirb_pkg::DATA_LAST)
								rx_state <= parity_enable ? uirb_pkg::RX_PAR : uirb_pkg::RX_STOP;
						end
					uirb_pkg::RX_PAR:
						if (bitv)
						begin
							rx_par <= vote;
							rx_state <= uirb_pkg::RX_STOP;
						end
					uirb_pkg::RX_STOP:
						if (bitv)
						begin
							if (two_stop && !rx_stop_cnt)
							begin
								rx_stop_cnt <= 1'b1;
								rx_stop_low <= !vote;
							end
							else
							begin
								rx_done <= 1'b1;
								rx_fe_c <= !vote || rx_stop_low;
								rx_pe_c <= parity_enable && ((^{rx_sh, rx_par}) == parity_even);
								rx_brk_c <= rx_sh == 8'h00 && !(parity_enable && rx_par) && !vote
									&& (!two_stop || rx_stop_low) && serial_mode_field != uirb_pkg::MODE_AUTOBAUD;
								ones_cnt <= 4'h0;
								rx_state <= (serial_mode_field == uirb_pkg::MODE_IDLE_LINE)
									? uirb_pkg::RX_WAITIDLE : uirb_pkg::RX_IDLE;
							end
						end
					default:
						rx_state <= uirb_pkg::RX_IDLE;
				endcase
			end
		end
	end

	// receive buffer and flags; a setting event wins over a read or write-one clear in the same cycle, soft reset wins over both
	wire err_c = rx_fe_c | rx_pe_c;
	wire store = rx_done & (!err_c | rx_error_irq_enable | (rx_brk_c & break_irq_enable));
	wire oe_set = store & rx_irq_flag & !rd_rxbuf;
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			rx_buffer <= 8'h00;
			rx_irq_flag <= 1'b0;
			framing_error_flag <= 1'b0;
			parity_error_flag <= 1'b0;
			overrun_flag <= 1'b0;
			break_flag <= 1'b0;
			rx_error_summary <= 1'b0;
			idle_line_flag <= 1'b0;
			ov_since_stat <= 1'b0;
		end
		else if (soft_reset_bit)
		begin
			rx_irq_flag <= 1'b0;
			framing_error_flag <= 1'b0;
			parity_error_flag <= 1'b0;
			overrun_flag <= 1'b0;
			break_flag <= 1'b0;
			rx_error_summary <= 1'b0;
			idle_line_flag <= 1'b0;
			ov_since_stat <= 1'b0;
		end
		else
		begin
			if (rd_status | rd_rxbuf)
				ov_since_stat <= 1'b0;
			if (rd_rxbuf)
			begin
				rx_irq_flag <= 1'b0;
				framing_error_flag <= 1'b0;
				parity_error_flag <= 1'b0;
				break_flag <= 1'b0;
				rx_error_summary <= 1'b0;
				if (!ov_since_stat)
					overrun_flag <= 1'b0;
			end
			// write one to clear; overrun ignores this path
			if (wr_status)
			begin
				if (pwdata[uirb_pkg::ST_FE])
					framing_error_flag <= 1'b0;
				if (pwdata[uirb_pkg::ST_PE])
					parity_error_flag <= 1'b0;
				if (pwdata[uirb_pkg::ST_BRK])
					break_flag <= 1'b0;
				if (pwdata[uirb_pkg::ST_RXERR])
					rx_error_summary <= 1'b0;
				if (pwdata[uirb_pkg::ST_IDLE])
					idle_line_flag <= 1'b0;
			end
			if (rx_done & rx_fe_c)
				framing_error_flag <= 1'b1;
			if (rx_done & rx_pe_c)
				parity_error_flag <= 1'b1;
			if (rx_done & rx_brk_c)
				break_flag <= 1'b1;
			if (oe_set)
			begin
				overrun_flag <= 1'b1;
				ov_since_stat <= 1'b1;
			end
			if ((rx_done & err_c) | oe_set)
				rx_error_summary <= 1'b1;
			if (store)
			begin
				rx_buffer <= rx_sh;
				rx_irq_flag <= 1'b1;
			end
			if (idle_set)
				idle_line_flag <= 1'b1;
		end
	end

	// transmitter
	logic tx_full;
	logic [11:0] tx_sh;
	logic [3:0] tx_left;
	logic [21:0] ir_cnt;
	wire tx_par_bit = ^tx_buffer ^ !parity_even;
	wire [11:0] tx_frame = parity_enable ? {2'b11, tx_par_bit, tx_buffer, 1'b0} : {3'b111, tx_buffer, 1'b0};
	wire [3:0] tx_len = uirb_pkg::FRAME_BASE_BITS + {3'h0, parity_enable} + {3'h0, two_stop};
	wire tx_last = tx_left == 4'h1;
	wire tx_load = gen_bend[1] && (tx_state == uirb_pkg::TX_WAIT
		|| (tx_state == uirb_pkg::TX_SHIFT && tx_last && tx_full));
	assign gen_run[1] = !soft_reset_bit && tx_state != uirb_pkg::TX_IDLE;
	assign gen_restart[1] = tx_load;

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			tx_buffer <= 8'h00;
			tx_full <= 1'b0;
			tx_irq_flag <= 1'b1;
		end
		else if (soft_reset_bit)
		begin
			tx_full <= 1'b0;
			tx_irq_flag <= 1'b1;
		end
		else
		begin
			if (tx_load)
			begin
				tx_full <= 1'b0;
				tx_irq_flag <= 1'b1;
			end
			if (wr_txbuf)
			begin
				tx_buffer <= pwdata[7:0];
				tx_full <= 1'b1;
				tx_irq_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			tx_state <= uirb_pkg::TX_IDLE;
			tx_sh <= 12'hFFF;
			tx_left <= 4'h0;
		end
		else if (soft_reset_bit)
		begin
			tx_state <= uirb_pkg::TX_IDLE;
			tx_sh <= 12'hFFF;
		end
		else if (tx_load)
		begin
			tx_state <= uirb_pkg::TX_SHIFT;
			tx_sh <= tx_frame;
			tx_left <= tx_len;
		end
		else
		begin
			case (tx_state)
				uirb_pkg::TX_IDLE:
					if (tx_full)
						tx_state <= uirb_pkg::TX_WAIT;
				uirb_pkg::TX_WAIT:
					tx_state <= uirb_pkg::TX_WAIT;
				uirb_pkg::TX_SHIFT:
					if (gen_bend[1])
					begin
						if (tx_last)
						begin
							tx_state <= uirb_pkg::TX_IDLE;
							tx_sh <= 12'hFFF;
						end
						else
						begin
							tx_sh <= {1'b1, tx_sh[11:1]};
							tx_left <= tx_left - 4'h1;
						end
					end
				default:
					tx_state <= uirb_pkg::TX_IDLE;
			endcase
		end
	end

	// infrared encoder: pulse length counted in half periods, rounded up to whole clocks
	wire ir_bit0 = tx_load | (tx_state == uirb_pkg::TX_SHIFT && gen_bend[1] && !tx_last && !tx_sh[1]);
	wire [22:0] ir_halves = {16'h0000, 7'({1'b0, ir_tx_pulse_len} + 7'h01)}
		* (ir_tx_pulse_clock_select ? {7'h00, baud_prescaler} : 23'h000001);
	wire [22:0] ir_len = (ir_halves + 23'h000001) >> 1;
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			ir_cnt <= 22'h0;
		else if (soft_reset_bit || !infrared_coding_enable)
			ir_cnt <= 22'h0;
		else if (ir_bit0)
			ir_cnt <= ir_len[21:0];
		else if (ir_cnt != 22'h0)
			ir_cnt <= ir_cnt - 22'h1;
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			serial_tx_line <= 1'b1;
		else
			serial_tx_line <= infrared_coding_enable ? (ir_cnt != 22'h0) : tx_sh[0];
	end

endmodule

// ### hw/uirb_pkg.sv
// uirb_pkg.sv - constants, modulation tables and state types of the serial/infrared core
// Functional notes
// - infrared encoder sends one pulse per zero bit, length (len+1) half clock periods
// - decoder takes high pulses with polarity 0, low pulses with polarity 1
// - with digital filter on, only pulses longer than filter length pass
// - receive pulses shorter than the 150 ns deglitch time are ignored
// - start bit is majority voted; a failed vote drops the character
// - low stop bit flags framing error; both stop bits checked when two
// - parity error when parity bit mismatches count of ones in character
// - overrun set when a character lands before the previous one was read
// - all-zero character sets break flag outside autobaud mode, and receive flag when break enable set
// - summary error flag set whenever framing, parity or overrun is set
// - errored character stored only when receive error enable is set, or for a break when break enable is set
// - error flags stay until cleared by software or buffer read; overrun only by read
// - buffer read keeps overrun if overwritten since status read; summary stays clear
// - receiver idles with generator stopped; start edge runs it, failed start stops it
// - idle-line mode sets idle flag after 10 ones without start, then stops
// - buffer write starts transmit generator; load on next bit clock; flag when free
// - transmitter runs back to back while buffer full, else idles and stops
// - low-frequency mode: bit is prescaler plus modulation clocks, 3-sample vote mid-bit
// - second stage uses 8-entry pattern, start bit never lengthened, restarts per start
// - oversampling mode: 16x clock from prescaler and modulator, bit from 16x clock
// - 16x periods lengthened per 16-entry first-stage pattern, restarting every bit
package uirb_pkg;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_BAUD = 8'h04;
	localparam logic [7:0] REG_IRCTL = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RXBUF = 8'h10;
	localparam logic [7:0] REG_TXBUF = 8'h14;
	localparam logic [7:0] REG_FLAGS = 8'h18;
	// control register fields
	localparam int CTRL_SWRST = 0;
	localparam int CTRL_OS16 = 1;
	localparam int CTRL_IREN = 2;
	localparam int CTRL_IRTXCLK = 3;
	localparam int CTRL_IRRXPL = 4;
	localparam int CTRL_IRRXFE = 5;
	localparam int CTRL_RXEIE = 6;
	localparam int CTRL_BRKIE = 7;
	localparam int CTRL_MODE = 8;
	localparam int CTRL_PAREN = 10;
	localparam int CTRL_PAREVEN = 11;
	localparam int CTRL_TWOSTOP = 12;
	localparam int CTRL_W = 13;
	localparam logic [12:0] CTRL_RESET = 13'h0001;
	// baud and infrared register fields
	localparam int BAUD_PRESC = 0;
	localparam int BAUD_MOD2 = 16;
	localparam int BAUD_MOD1 = 20;
	localparam int IR_TXPL = 0;
	localparam int IR_RXFL = 8;
	// status and flags register fields
	localparam int ST_FE = 0;
	localparam int ST_PE = 1;
	localparam int ST_OE = 2;
	localparam int ST_BRK = 3;
	localparam int ST_RXERR = 4;
	localparam int ST_IDLE = 5;
	localparam int ST_RXBUSY = 6;
	localparam int ST_TXBUSY = 7;
	localparam int FL_RX = 0;
	localparam int FL_TX = 1;
	// modes
	localparam logic [1:0] MODE_IDLE_LINE = 2'h1;
	localparam logic [1:0] MODE_AUTOBAUD = 2'h3;
	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int DEGLITCH_NS = 150;
	localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] DEGLITCH_LAST = 5'(DEGLITCH_CYC - 1);
	localparam logic [3:0] DATA_LAST = 4'h7;
	localparam int IDLE_ONES = 10;
	localparam logic [3:0] IDLE_LAST = 4'(IDLE_ONES - 1);
	localparam logic [3:0] FRAME_BASE_BITS = 4'hA;
	localparam logic [4:0] OS_LAST_TICK = 5'h0F;
	localparam logic [4:0] OS_SAMP_TICK = 5'h06;
	localparam logic [20:0] IR_STRETCH_OS = 21'h00000C;
	localparam logic [20:0] IR_STRETCH_LF = 21'h000003;
	localparam logic [6:0] IR_PW_MAX = 7'h7F;
	// modulation patterns, bit i is the lengthening of bit (or 16x period) i
	localparam logic [7:0] M2_TAB [0:7] = '{8'h00, 8'h02, 8'h22, 8'h2A, 8'hAA, 8'hAE, 8'hEE, 8'hFE};
	localparam logic [15:0] M1_TAB [0:15] = '{16'h0000, 16'h0002, 16'h8002, 16'h8006, 16'hC006, 16'hC00E,
		16'hE00E, 16'hE01E, 16'hF01E, 16'hF03E, 16'hF83E, 16'hF87E, 16'hFC7E, 16'hFCFE, 16'hFEFE, 16'hFFFE};
	// state machines
	typedef enum logic [2:0]
	{
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b010,
		RX_PAR = 3'b011,
		RX_STOP = 3'b100,
		RX_WAITIDLE = 3'b101
	} uirb_rx_state_t;
	typedef enum logic [1:0]
	{
		TX_IDLE = 2'b00,
		TX_WAIT = 2'b01,
		TX_SHIFT = 2'b10
	} uirb_tx_state_t;
endpackage

// ### dv/uirb_monitor.sv
// port checker for the serial core
`timescale 1ns/1ns
module uirb_monitor
(
	// clock, reset, bus
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// flags
	input wire logic rx_irq_flag,
	input wire logic tx_irq_flag
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire acc = psel && penable && pready;
	rdy_after_setup_a: assert property (psel && !penable |=> pready) else $error("no ready");
	rdy_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
	err_with_rdy_a: assert property (pslverr |-> pready) else $error("stray error");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
	unmapped_err_a: assert property (psel && !penable && paddr > 8'h18 |=> pslverr) else $error("no error");
	mapped_ok_a: assert property (psel && !penable && paddr <= 8'h18 && paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("false error");
	txbuf_clear_a: assert property (acc && pwrite && paddr == 8'h14 |=> !tx_irq_flag) else $error("tx flag");
	rxbuf_clear_a: assert property (acc && !pwrite && paddr == 8'h10 |=> !rx_irq_flag) else $error("rx flag");
	cover property (acc && pslverr);
	cover property ($rose(rx_irq_flag));
	cover property (acc && pwrite && paddr == 8'h14);
endmodule
bind uirb_top uirb_monitor mon(.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
	.rx_irq_flag, .tx_irq_flag);

// ### dv/uirb_partner.sv
// remote serial station: sends frames, captures transmitted characters
`timescale 1ns/1ns
module uirb_partner
#(
	parameter int BIT = 48
)
(
	input wire logic sys_clk,
	input wire logic tx_in,
	output logic rx_out
);
	logic [7:0] got [$];
	logic [7:0] sh;
	initial rx_out = 1'b1;
	// frame bits go out lsb first, the caller builds start, parity and stops
	task automatic send(input logic [10:0] f, input int n);
		for (int i = 0; i < n; i++)
		begin
			rx_out <= f[i];
			repeat (BIT) @(posedge sys_clk);
		end
		// one idle bit time closes each frame, so the receiver has finished when send returns
		rx_out <= 1'b1;
		repeat (BIT) @(posedge sys_clk);
	endtask
	task automatic glitch(input int n);
		rx_out <= 1'b0;
		repeat (n) @(posedge sys_clk);
		rx_out <= 1'b1;
	endtask
	// samples mid-bit; modulation drift stays well inside half a bit
	always
	begin
		@(negedge tx_in);
		repeat (BIT / 2) @(posedge sys_clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT) @(posedge sys_clk);
			sh[i] = tx_in;
		end
		repeat (BIT) @(posedge sys_clk);
		got.push_back(sh);
	end
endmodule

// ### dv/test_uart_irda_rx_tx_baudgen.sv
// self-checking bench for the serial core
`timescale 1ns/1ns
module test_uart_irda_rx_tx_baudgen;
	localparam int P = 48;
	logic sys_clk, rst_n, psel, penable, pwrite, rxl, txl, rxf, txf, pready, pslverr, r_err;
	logic [7:0] paddr, d, e;
	logic [31:0] pwdata, prdata, r;
	integer seed;
	int fail_count, num_checks;
	uirb_top dut(.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.serial_rx_line(rxl), .serial_tx_line(txl), .rx_irq_flag(rxf), .tx_irq_flag(txf));
	uirb_partner #(.BIT(P)) peer(.sys_clk, .tx_in(txl), .rx_out(rxl));
	initial
	begin
		sys_clk = 0;
		forever #4 sys_clk = ~sys_clk;
	end
	task chk(input string n, input logic [31:0] ex, input logic [31:0] got);
		num_checks++;
		if (got !== ex)
		begin
			fail_count++;
			$display("unexpected %s exp %h got %h", n, ex, got);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		r = prdata;
		r_err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wait_rx;
		for (int n = 0; n < 2000 && rxf !== 1'b1; n++) @(posedge sys_clk);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		#400000;
		fail_count++;
		wrap_up;
	end
	initial
	begin
		seed = 32'h03e98b9b;
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1;
		repeat (3) @(posedge sys_clk);
		apb(0, 8'h00, 0); chk("ctrl", 32'h1, r);
		apb(0, 8'h18, 0); chk("flags", 32'h2, r);
		apb(0, 8'h40, 0); chk("slverr", 1, r_err);
		apb(1, 8'h04, (($random(seed) & 7) << 16) | P);
		apb(1, 8'h00, 0);
		$display("test regs done");
		repeat (4)
		begin
			d = $random(seed);
			peer.send({2'b11, d, 1'b0}, 10);
			wait_rx;
			apb(0, 8'h10, 0); chk("rxbuf", d, r);
		end
		d = $random(seed);
		e = $random(seed);
		peer.send({2'b11, d, 1'b0}, 10);
		peer.send({2'b11, e, 1'b0}, 10);
		apb(0, 8'h0C, 0); chk("ovr", 32'h14, r & 32'h1F);
		apb(0, 8'h10, 0); chk("rx2", e, r);
		apb(0, 8'h0C, 0); chk("ovrclr", 0, r & 32'h1F);
		peer.send({2'b11, d, 1'b0}, 10);
		apb(0, 8'h0C, 0);
		peer.send({2'b11, e, 1'b0}, 10);
		apb(0, 8'h10, 0);
		apb(0, 8'h0C, 0); chk("ovrkeep", 32'h04, r & 32'h1F);
		apb(0, 8'h10, 0);
		$display("test overrun done");
		d = $random(seed) | 1;
		peer.send({2'b10, d, 1'b0}, 10);
		repeat (100) @(posedge sys_clk);
		chk("nostore", 0, rxf);
		apb(0, 8'h0C, 0); chk("fe", 32'h11, r & 32'h1F);
		apb(1, 8'h0C, 32'h1F);
		apb(0, 8'h0C, 0); chk("feclr", 0, r & 32'h1F);
		apb(1, 8'h00, 32'h1040);
		peer.send({1'b0, 1'b1, d, 1'b0}, 11);
		wait_rx;
		apb(0, 8'h0C, 0); chk("fe2", 32'h11, r & 32'h1F);
		apb(0, 8'h10, 0); chk("festore", d, r);
		apb(1, 8'h00, 32'h80);
		peer.send(11'h0, 10);
		wait_rx;
		apb(0, 8'h0C, 0); chk("brk", 32'h19, r & 32'h1F);
		apb(0, 8'h10, 0); chk("brkbuf", 0, r);
		apb(1, 8'h00, 32'hC40);
		for (int b = 0; b < 2; b++)
		begin
			d = $random(seed);
			peer.send({1'b1, ^d ^ b[0], d, 1'b0}, 11);
			wait_rx;
			apb(0, 8'h0C, 0); chk("par", b ? 32'h12 : 0, r & 32'h1F);
			apb(0, 8'h10, 0); chk("parbuf", d, r);
		end
		peer.glitch(10);
		repeat (200) @(posedge sys_clk);
		apb(0, 8'h0C, 0); chk("glitch", 0, r & 32'hFF);
		apb(1, 8'h00, 32'h140);
		peer.send({2'b11, d, 1'b0}, 10);
		repeat (12 * P) @(posedge sys_clk);
		apb(0, 8'h0C, 0); chk("idle", 32'h20, r & 32'h7F);
		apb(0, 8'h10, 0);
		apb(1, 8'h00, 32'h14);
		peer.send({2'b11, 8'h55, 1'b0}, 10);
		wait_rx;
		apb(0, 8'h10, 0); chk("irrx", 8'h55, r);
		apb(1, 8'h04, 3);
		apb(1, 8'h00, 32'h2);
		d = $random(seed);
		peer.send({2'b11, d, 1'b0}, 10);
		wait_rx;
		apb(0, 8'h10, 0); chk("os16", d, r);
		apb(1, 8'h04, P);
		$display("test receive done");
		apb(1, 8'h00, 0);
		peer.got.delete();
		d = $random(seed);
		e = $random(seed);
		apb(1, 8'h14, d);
		@(posedge sys_clk);
		for (int n = 0; n < 2000 && txf !== 1'b1; n++) @(posedge sys_clk);
		apb(1, 8'h14, e);
		for (int n = 0; n < 9000 && peer.got.size() < 2; n++) @(posedge sys_clk);
		chk("tx0", d, peer.got[0]);
		chk("tx1", e, peer.got[1]);
		$display("test transmit done");
		wrap_up;
	end
endmodule
